/* File: inc/fcps_pkg.sv */
// Shared constants and types for the configuration loading port sequencer.
// Assumes a 10 MHz system clock; all cycle counts below derive from that rate.
package fcps_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 12;

  // Generated clock: lowest allowed frequency of each rate, in kHz.
  // The divider picks the longest half period that still meets it.
  localparam int CONFIG_CLOCK_FAST_MIN_KHZ = 5000;
  localparam int CONFIG_CLOCK_SLOW_MIN_KHZ = 630;
  localparam logic [2:0] CONFIG_CLOCK_FAST_HALF_CYC = 3'(1000000 / (2 * CONFIG_CLOCK_FAST_MIN_KHZ * CLK_PERIOD_NS));
  localparam logic [2:0] CONFIG_CLOCK_SLOW_HALF_CYC = 3'(1000000 / (2 * CONFIG_CLOCK_SLOW_MIN_KHZ * CLK_PERIOD_NS));

  // Least initialisation latency after the program request is released.
  localparam int INIT_LAT_NS = 210000;
  localparam logic [CNT_W-1:0] INIT_LAT_CYC = CNT_W'((INIT_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Delay from the initialisation flag to the first generated clock edge.
  localparam int CONFIG_CLOCK_START_NS = 1000;
  localparam int CONFIG_CLOCK_START_PAR_SLOW_NS = 4800;
  localparam logic [CNT_W-1:0] CONFIG_CLOCK_START_CYC = CNT_W'((CONFIG_CLOCK_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CONFIG_CLOCK_START_PAR_SLOW_CYC =
    CNT_W'((CONFIG_CLOCK_START_PAR_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Host wait after the initialisation flag before its first write.
  localparam int INIT_TO_WRITE_NS = 2000;

  // Read strobe position in its eight-clock period.
  localparam logic [2:0] STROBE_HIGH_SLOT = 3'h7;
  localparam logic [2:0] STROBE_LAST_LOW = 3'h6;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [2:0] {
    MODE_MSER = 3'h0,
    MODE_MPAR = 3'h1,
    MODE_APER = 3'h2,
    MODE_SSER = 3'h3,
    MODE_SPAR = 3'h4
  } fcps_mode_t;

  typedef enum logic [1:0] {
    ST_CLEAR = 2'h0,
    ST_INIT = 2'h1,
    ST_START = 2'h2,
    ST_RUN = 2'h3
  } fcps_state_t;

  typedef struct packed {
    logic chip_select_low_n;
    logic chip_select_high;
    logic write_n;
    logic read_n;
    logic [BYTE_W-1:0] data;
  } fcps_host_bus_t;

  typedef struct packed {
    logic valid;
    logic [BYTE_W-1:0] data;
  } fcps_cfg_t;

endpackage

/* File: hw/fcps_sync.sv */
// Two-flop synchroniser for a vector of pin inputs.
// Assumes each bit is an independent level; multi-bit words must be stable when sampled.
`timescale 1ns/10ps
`default_nettype none
module fcps_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule
`default_nettype wire

/* File: hw/fcps_top.sv */
// Configuration loading port: mode sequencing, clock generation and data forwarding.
// Assumes every pin input is asynchronous to clk; two-way pins are split into in/out/enable.
// Function
// - serial bit forwarded on next falling edge, in fast master serial on the one after
// - master serial samples on rising edge
// - fast generated clock within 5-16.67 MHz
// - slow generated clock within 0.63-2.08 MHz
// - read strobe seven clocks low, one high
// - fetched byte shifts out 1.5 clocks later
// - written byte shifts out on falling edges
// - ready shown on ready pin and bit7
// - read strobe drives only data bit 7
// - no forwarding in slave parallel mode
// - clock starts bounded time after init flag
// - clear memory, then raise init flag
`timescale 1ns/10ps
`default_nettype none
module fcps_top #(
  parameter int ADDR_W = 18
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic program_request_n,
  input wire logic [2:0] mode_sel,
  input wire logic clock_rate_select,
  input wire logic config_clock_i,
  output logic config_clock_o,
  output logic config_clock_oe,
  input wire logic serial_in,
  output logic serial_out,
  input wire fcps_pkg::fcps_host_bus_t host_bus,
  output logic status_data_bit_o,
  output logic status_data_bit_oe,
  output logic ready,
  output logic read_strobe,
  output logic [ADDR_W-1:0] mem_addr,
  output logic init_flag,
  output logic mem_clear,
  output fcps_pkg::fcps_cfg_t cfg_stream
);
  import fcps_pkg::*;

  localparam int SYNC_W = 7 + $bits(fcps_host_bus_t);

  logic rst_m_r, rst_s_r;
  logic [SYNC_W-1:0] sync_w;
  logic prog_s_n, rate_s, config_clock_s, din_s;
  logic [2:0] mode_pin_s;
  fcps_host_bus_t hb_s;
  logic config_clock_d_r, wr_d_r;
  fcps_state_t st_r;
  logic [CNT_W-1:0] cnt_r;
  fcps_mode_t mode_r;
  logic rate_r, init_r, clear_r;
  logic [2:0] div_r;
  logic config_clock_r, config_clock_oe_r;
  logic [1:0] rise_d_r;
  logic bit_r, pend_r;
  logic [BYTE_W-1:0] asm_r, hold_r, sh_r;
  logic [2:0] asm_cnt_r, sh_cnt_r, str_cnt_r;
  logic hold_full_r, hold_aged_r, dout_r, strobe_r, ready_r, d7_r, d7_oe_r;
  logic [ADDR_W-1:0] addr_r;
  logic fetched_r;
  fcps_cfg_t cfg_r;
  logic run, gen_clk, serial_mode, selected, tick, rise_ev, fall_ev, cap_ev;
  logic fetch_ev, acc_ev, sp_ev, load_ev, asm_done, ready_nxt;
  logic [2:0] half;
  logic [CNT_W-1:0] start_cyc;

  // Reset asserts at once and releases through two flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  fcps_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk(clk),
    .rst_n(rst_s_r),
    .async_in({program_request_n, mode_sel, clock_rate_select, config_clock_i, serial_in, host_bus}),
    .sync_out(sync_w)
  );
  assign {prog_s_n, mode_pin_s, rate_s, config_clock_s, din_s, hb_s} = sync_w;

  // Third stage for edge detection reads only the settled copies.
  always_ff @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      config_clock_d_r <= 1'b0;
      wr_d_r <= 1'b1;
    end else begin
      config_clock_d_r <= config_clock_s;
      wr_d_r <= hb_s.write_n;
    end
  end

  assign run = (st_r == ST_RUN);
  assign gen_clk = (mode_r == MODE_MSER) || (mode_r == MODE_MPAR) || (mode_r == MODE_APER);
  assign serial_mode = (mode_r == MODE_MSER) || (mode_r == MODE_SSER);
  assign selected = !hb_s.chip_select_low_n && hb_s.chip_select_high;
  assign start_cyc = (mode_r == MODE_MPAR && rate_r) ? CONFIG_CLOCK_START_PAR_SLOW_CYC : CONFIG_CLOCK_START_CYC;

  always_ff @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      st_r <= ST_CLEAR;
      cnt_r <= '0;
      mode_r <= MODE_SSER;
      rate_r <= 1'b0;
      init_r <= 1'b0;
      clear_r <= 1'b1;
    end else if (!prog_s_n) begin
      st_r <= ST_CLEAR;
      cnt_r <= '0;
      init_r <= 1'b0;
      clear_r <= 1'b1;
    end else begin
      case (st_r)
        ST_CLEAR: begin
          st_r <= ST_INIT;
          cnt_r <= '0;
        end
        ST_INIT: begin
          if (cnt_r == INIT_LAT_CYC - 1'b1) begin
            st_r <= ST_START;
            cnt_r <= '0;
            init_r <= 1'b1;
            clear_r <= 1'b0;
            // Mode straps are held past the flag, so they are caught here.
            rate_r <= rate_s;
            case (mode_pin_s)
              MODE_MSER: mode_r <= MODE_MSER;
              MODE_MPAR: mode_r <= MODE_MPAR;
              MODE_APER: mode_r <= MODE_APER;
              MODE_SPAR: mode_r <= MODE_SPAR;
              default: mode_r <= MODE_SSER;
            endcase
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_START: begin
          if (cnt_r == start_cyc - 1'b1) begin
            st_r <= ST_RUN;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_RUN: st_r <= ST_RUN;
        default: st_r <= ST_CLEAR;
      endcase
    end
  end

  assign half = rate_r ? CONFIG_CLOCK_SLOW_HALF_CYC : CONFIG_CLOCK_FAST_HALF_CYC;
  assign tick = (div_r == half - 1'b1);
  always_ff @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      div_r <= '0;
      config_clock_r <= 1'b0;
      config_clock_oe_r <= 1'b0;
    end else begin
      config_clock_oe_r <= run && gen_clk;
      if (!run || !gen_clk) begin
        div_r <= '0;
        config_clock_r <= 1'b0;
      end else if (tick) begin
        div_r <= '0;
        config_clock_r <= !config_clock_r;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  assign rise_ev = run && (gen_clk ? (tick && !config_clock_r) : (config_clock_s && !config_clock_d_r));
  assign fall_ev = run && (gen_clk ? (tick && config_clock_r) : (!config_clock_s && config_clock_d_r));

  always_ff @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      rise_d_r <= '0;
    end else begin
      rise_d_r <= {rise_d_r[0], rise_ev};
    end
  end
  // The pin is seen two cycles late, so a master samples two cycles after its own edge.
  assign cap_ev = serial_mode && ((mode_r == MODE_MSER) ? rise_d_r[1] : rise_ev);

  always_ff @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      bit_r <= 1'b0;
      pend_r <= 1'b0;
      asm_r <= '0;
      asm_cnt_r <= '0;
    end else if (!run) begin
      // A new run starts a fresh byte, so a restart never mixes bits from the old mode.
      pend_r <= 1'b0;
      asm_cnt_r <= '0;
    end else if (cap_ev) begin
      bit_r <= din_s;
      pend_r <= 1'b1;
      asm_r <= {asm_r[BYTE_W-2:0], din_s};
      asm_cnt_r <= asm_cnt_r + 1'b1;
    end else if (fall_ev) begin
      pend_r <= 1'b0;
    end
  end
  assign asm_done = cap_ev && (asm_cnt_r == BIT_LAST);

  always_ff @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      str_cnt_r <= STROBE_HIGH_SLOT;
      strobe_r <= 1'b1;
      addr_r <= '0;
      fetched_r <= 1'b0;
    end else if (!run || mode_r != MODE_MPAR) begin
      str_cnt_r <= STROBE_HIGH_SLOT;
      strobe_r <= 1'b1;
      if (!run) begin
        addr_r <= '0;
        fetched_r <= 1'b0;
      end
    end else if (rise_ev) begin
      str_cnt_r <= str_cnt_r + 1'b1;
      strobe_r <= (str_cnt_r == STROBE_LAST_LOW);
      if (str_cnt_r == STROBE_LAST_LOW) fetched_r <= 1'b1;
      // The address moves as the strobe falls, so the memory has the whole low phase to settle.
      if (str_cnt_r == STROBE_HIGH_SLOT && fetched_r) begin
        addr_r <= addr_r + 1'b1;
      end
    end
  end

  assign fetch_ev = (mode_r == MODE_MPAR) && rise_ev && (str_cnt_r == STROBE_LAST_LOW);
  assign acc_ev = run && (mode_r == MODE_APER) && selected && hb_s.write_n && !wr_d_r && !hold_full_r;
  assign sp_ev = (mode_r == MODE_SPAR) && rise_ev && selected && !hb_s.write_n;
  assign load_ev = fall_ev && (sh_cnt_r == '0) && hold_full_r && hold_aged_r;

  always_ff @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      hold_r <= '0;
      hold_full_r <= 1'b0;
      hold_aged_r <= 1'b0;
    end else if (!run) begin
      hold_full_r <= 1'b0;
      hold_aged_r <= 1'b0;
    end else if (fetch_ev || acc_ev) begin
      hold_r <= hb_s.data;
      hold_full_r <= 1'b1;
      hold_aged_r <= 1'b0;
    end else if (load_ev) begin
      hold_full_r <= 1'b0;
    end else if (rise_ev && hold_full_r) begin
      hold_aged_r <= 1'b1;
    end
  end

  // slave parallel keeps serial output idle
  always_ff @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      dout_r <= 1'b1;
      sh_r <= '0;
      sh_cnt_r <= '0;
    end else if (!run || mode_r == MODE_SPAR) begin
      dout_r <= 1'b1;
      sh_cnt_r <= '0;
    end else if (serial_mode) begin
      if (fall_ev && pend_r) dout_r <= bit_r;
    end else if (fall_ev && sh_cnt_r != '0) begin
      dout_r <= sh_r[BYTE_W-1];
      sh_r <= {sh_r[BYTE_W-2:0], 1'b0};
      sh_cnt_r <= sh_cnt_r - 1'b1;
    end else if (load_ev) begin
      dout_r <= hold_r[BYTE_W-1];
      sh_r <= {hold_r[BYTE_W-2:0], 1'b0};
      sh_cnt_r <= BIT_LAST;
    end
  end

  assign ready_nxt = run && (mode_r == MODE_APER) && !hold_full_r && !acc_ev;
  always_ff @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      ready_r <= 1'b0;
      d7_r <= 1'b0;
      d7_oe_r <= 1'b0;
    end else begin
      ready_r <= ready_nxt;
      d7_r <= ready_nxt;
      d7_oe_r <= run && (mode_r == MODE_APER) && selected && !hb_s.read_n;
    end
  end

  always_ff @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      cfg_r <= '0;
    end else begin
      cfg_r.valid <= asm_done || fetch_ev || acc_ev || sp_ev;
      if (asm_done) cfg_r.data <= {asm_r[BYTE_W-2:0], din_s};
      else if (fetch_ev || acc_ev || sp_ev) cfg_r.data <= hb_s.data;
    end
  end

  assign config_clock_o = config_clock_r;
  assign config_clock_oe = config_clock_oe_r;
  assign serial_out = dout_r;
  assign status_data_bit_o = d7_r;
  assign status_data_bit_oe = d7_oe_r;
  assign ready = ready_r;
  assign read_strobe = strobe_r;
  assign mem_addr = addr_r;
  assign init_flag = init_r;
  assign mem_clear = clear_r;
  assign cfg_stream = cfg_r;

  // Helper: rising edges seen while the read strobe is low.
  logic [3:0] low_rises_r;
  always_ff @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) low_rises_r <= '0;
    else if (strobe_r) low_rises_r <= '0;
    else if (rise_ev) low_rises_r <= low_rises_r + 1'b1;
  end

  strobe_low_a: assert property (@(posedge clk) disable iff (!rst_s_r)
    ($rose(read_strobe) && run) |-> low_rises_r == 4'h7) else $error("read strobe low length wrong");
  fast_clock_a: assert property (@(posedge clk) disable iff (!rst_s_r)
    (run && $past(run) && gen_clk && !rate_r) |-> config_clock_o != $past(config_clock_o))
    else $error("fast generated clock did not toggle");
  slow_clock_a: assert property (@(posedge clk) disable iff (!rst_s_r || !prog_s_n)
    ($rose(config_clock_o) && run && gen_clk && rate_r) |-> config_clock_o [*7] ##1 !config_clock_o)
    else $error("slow generated clock half period wrong");
  forward_fall_a: assert property (@(posedge clk) disable iff (!rst_s_r)
    (run && $past(run) && serial_mode && $changed(serial_out)) |-> $past(fall_ev))
    else $error("serial output changed off a falling edge");
  ready_mirror_a: assert property (@(posedge clk) disable iff (!rst_s_r)
    status_data_bit_oe |-> status_data_bit_o == ready) else $error("bit 7 differs from ready");
  bit7_only_a: assert property (@(posedge clk) disable iff (!rst_s_r)
    status_data_bit_oe |-> mode_r == MODE_APER && $past(!hb_s.read_n)) else $error("bit 7 driven without read");
  no_chain_a: assert property (@(posedge clk) disable iff (!rst_s_r)
    (mode_r == MODE_SPAR && run && $past(run)) |-> serial_out) else $error("slave parallel forwarded data");
  init_latency_a: assert property (@(posedge clk) disable iff (!rst_s_r)
    $rose(init_flag) |-> $past(st_r) == ST_INIT && $past(cnt_r) == INIT_LAT_CYC - 1'b1 && !mem_clear)
    else $error("init flag rose before latency");
  clock_start_a: assert property (@(posedge clk) disable iff (!rst_s_r)
    ($rose(init_flag) && gen_clk) |-> ##[1:170] config_clock_oe) else $error("generated clock started late");
  ready_low_a: assert property (@(posedge clk) disable iff (!rst_s_r)
    ($fell(ready) && mode_r == MODE_APER && run) |-> ##[1:200] ready) else $error("ready held low too long");
endmodule
`default_nettype wire

/* File: tb/fcps_mem_model.sv */
// Far side of the port: serial ROM and byte-wide configuration memory.
// Assumes the bench puts rom_bit and mem_data on the pins only in the matching master mode.
`timescale 1ns/10ps
`default_nettype none
module fcps_mem_model #(
  parameter int ADDR_W = 18,
  parameter logic [7:0] ROM_BYTE = 8'hC5
) (
  input wire logic config_clock_o,
  input wire logic config_clock_oe,
  input wire logic read_strobe,
  input wire logic [ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_data,
  output logic rom_bit
);
  logic [2:0] idx_r;
  initial begin
    idx_r = 3'h0;
    mem_data = 8'hFF;
  end
  // next bit settled
  // The ROM moves on just after each fall, so the bit is steady well before the next rise.
  always @(negedge config_clock_o or negedge config_clock_oe) begin
    #1 idx_r = config_clock_oe ? idx_r + 3'h1 : 3'h0;
  end
  assign rom_bit = ROM_BYTE[3'h7 - idx_r];
  // Outside a read the lines show the inverse of the last byte, never a held copy.
  always @(read_strobe or mem_addr) begin
    mem_data = read_strobe ? ~mem_data : (mem_addr[7:0] ^ 8'hA5);
  end
endmodule
`default_nettype wire

/* File: tb/tb_fcps_top.sv */
// Bench for the configuration port: one task per mode (two for master serial, one per rate), partner memory beside the dut.
// Assumes clk at 10 MHz; the link clock runs only inside frames and rests low between them.
`timescale 1ns/10ps
`default_nettype none
module tb_fcps_top;
  import fcps_pkg::*;
  logic clk, rst_n, program_request_n, clock_rate_select, config_clock_i, tb_sin, use_rom, use_mem;
  logic config_clock_o, config_clock_oe, serial_out, status_data_bit_o, status_data_bit_oe, ready;
  logic read_strobe, init_flag, mem_clear, rom_bit, in_spar, spar_bad;
  logic [2:0] mode_sel;
  logic [17:0] mem_addr;
  logic [7:0] mem_data, last_byte;
  fcps_host_bus_t hb, bus;
  fcps_cfg_t cfg_stream;
  int err_total, checks, cyc, nbytes;
  fcps_top dut (.clk(clk), .rst_n(rst_n), .program_request_n(program_request_n), .mode_sel(mode_sel),
    .clock_rate_select(clock_rate_select), .config_clock_i(config_clock_i), .config_clock_o(config_clock_o),
    .config_clock_oe(config_clock_oe), .serial_in(use_rom ? rom_bit : tb_sin), .serial_out(serial_out),
    .host_bus(bus), .status_data_bit_o(status_data_bit_o), .status_data_bit_oe(status_data_bit_oe),
    .ready(ready), .read_strobe(read_strobe), .mem_addr(mem_addr), .init_flag(init_flag),
    .mem_clear(mem_clear), .cfg_stream(cfg_stream));
  fcps_mem_model mem (.config_clock_o(config_clock_o), .config_clock_oe(config_clock_oe),
    .read_strobe(read_strobe), .mem_addr(mem_addr), .mem_data(mem_data), .rom_bit(rom_bit));
  always_comb begin
    bus = hb;
    if (use_mem) begin
      bus.data = mem_data;
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cfg_stream.valid === 1'b1) begin
      last_byte <= cfg_stream.data;
      nbytes <= nbytes + 1;
    end
    if (!in_spar) begin
      spar_bad <= 1'b0;
    end else if (serial_out !== 1'b1) begin
      spar_bad <= 1'b1;
    end
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic restart(input logic [2:0] m, input logic r);
    int n;
    @(posedge clk);
    program_request_n <= 1'b0;
    mode_sel <= m;
    clock_rate_select <= r;
    use_rom <= (m == 3'h0);
    use_mem <= (m == 3'h1);
    hb <= '{1'b1, 1'b0, 1'b1, 1'b1, 8'h00};
    repeat (4) @(posedge clk);
    program_request_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("mem_clear", mem_clear, 1);
    n = 8;
    while (init_flag !== 1'b1 && n < 16000) begin
      @(posedge clk);
      n++;
    end
    chk("init_lat", n >= 2100 && n <= 15000, 1);
    chk("clear_end", mem_clear, 0);
  endtask
  task automatic wait_oe(input int lim);
    int n;
    n = 0;
    while (config_clock_oe !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("clk_start", n >= 1 && n <= lim, 1);
  endtask
  task automatic chk_period(input int lo, input int hi);
    realtime t0;
    @(posedge config_clock_o);
    t0 = $realtime;
    @(posedge config_clock_o);
    chk("period", $realtime - t0 >= lo && $realtime - t0 <= hi, 1);
  endtask
  task automatic get_byte(input logic [7:0] exp);
    int n;
    n = 0;
    while (cfg_stream.valid !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("cfg_byte", cfg_stream.data, exp);
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] d);
    hb.data <= d;
    hb.write_n <= 1'b0;
    repeat (2) @(posedge clk);
    hb.write_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic lpulse(input logic d, input logic en, input logic exp);
    tb_sin <= d;
    repeat (4) @(posedge clk);
    config_clock_i <= 1'b1;
    repeat (2) @(posedge clk);
    if (en) begin
      chk("serial_out", serial_out, exp);
    end
    repeat (2) @(posedge clk);
    config_clock_i <= 1'b0;
  endtask
  task automatic t_mser_fast();
    restart(3'h0, 1'b0);
    wait_oe(34);
    chk_period(60, 200);
    get_byte(8'hC5);
  endtask
  task automatic t_mser_slow();
    logic b;
    restart(3'h0, 1'b1);
    wait_oe(34);
    chk_period(480, 1588);
    repeat (8) begin
      @(posedge config_clock_o);
      #2 b = rom_bit;
      @(negedge config_clock_o);
      #2 chk("serial_out", serial_out, b);
    end
    get_byte(8'hC5);
  endtask
  task automatic t_mpar();
    realtime t0;
    restart(3'h1, 1'b0);
    wait_oe(36);
    get_byte(8'hA5);
    @(posedge read_strobe);
    @(negedge config_clock_o);
    for (int i = 7; i >= 0; i--) begin
      @(negedge config_clock_o);
      #2 chk("mpar_bit", serial_out, (8'hA4 >> i) & 8'h01);
    end
    @(negedge read_strobe);
    t0 = $realtime;
    @(posedge read_strobe);
    chk("strobe_low", int'($realtime - t0), 1400);
    t0 = $realtime;
    @(negedge read_strobe);
    chk("strobe_high", int'($realtime - t0), 200);
  endtask
  task automatic t_aper();
    int n, m0;
    restart(3'h2, 1'b0);
    repeat (INIT_TO_WRITE_NS / CLK_PERIOD_NS) @(posedge clk);
    hb.chip_select_low_n <= 1'b0;
    hb.chip_select_high <= 1'b1;
    hb.read_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk("status_oe", status_data_bit_oe, 1);
    chk("status_idle", status_data_bit_o, 1);
    chk("ready_idle", ready, 1);
    hb.read_n <= 1'b1;
    m0 = nbytes;
    wr(8'h96);
    @(posedge clk);
    chk("ready_busy", ready, 0);
    chk("status_off", status_data_bit_oe, 0);
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("ready_low", n <= 16, 1);
    wr(8'h69);
    hb.read_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk("status_busy", status_data_bit_o, 0);
    hb.read_n <= 1'b1;
    repeat (200) @(posedge clk);
    chk("aper_bytes", nbytes - m0, 2);
    chk("aper_last", last_byte, 8'h69);
  endtask
  task automatic t_sser();
    logic [7:0] pat;
    pat = 8'h5A;
    restart(3'h3, 1'b0);
    repeat (16) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      lpulse((i < 8) ? pat[7-i] : ~pat[0], i > 0, pat[(8-i)%8]);
    end
    @(posedge clk);
    chk("sser_byte", last_byte, 8'h5A);
  endtask
  task automatic t_spar();
    restart(3'h4, 1'b0);
    hb.chip_select_low_n <= 1'b0;
    hb.chip_select_high <= 1'b1;
    hb.write_n <= 1'b0;
    hb.data <= 8'h3E;
    in_spar <= 1'b1;
    repeat (16) @(posedge clk);
    lpulse(1'b0, 1'b0, 1'b0);
    hb.write_n <= 1'b1;
    lpulse(1'b0, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    chk("spar_byte", last_byte, 8'h3E);
    chk("spar_chain", spar_bad, 0);
    in_spar <= 1'b0;
  endtask
  initial begin
    rst_n = 1'b0;
    program_request_n = 1'b1;
    mode_sel = 3'h3;
    clock_rate_select = 1'b0;
    config_clock_i = 1'b0;
    tb_sin = 1'b0;
    use_rom = 1'b0;
    use_mem = 1'b0;
    in_spar = 1'b0;
    hb = '{1'b1, 1'b0, 1'b1, 1'b1, 8'h00};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_mser_fast();
    t_mser_slow();
    t_mpar();
    t_aper();
    t_sser();
    t_spar();
    tally_and_finish();
  end
endmodule
`default_nettype wire
